// file: verilog/cmpctl_pkg.sv
// cmpctl_pkg: register map, field positions and encodings of the comparator
`default_nettype none
package cmpctl_pkg;
  // -----------------------------------------------------------------
  // register offsets on the special-function register bus
  // -----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h9B;
  localparam logic [7:0] MODE_ADDR = 8'h9D;
  localparam logic [7:0] MUX0_ADDR = 8'h9F;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h02;
  localparam logic [7:0] MUX0_RST = 8'hFF;
  localparam logic [1:0] RESP_MODE_RST = 2'h2;
  // -----------------------------------------------------------------
  // control register fields
  // -----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_RES_BIT = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_HYP_LSB = 2;
  localparam int CTRL_HYN_LSB = 0;
  // -----------------------------------------------------------------
  // mode register fields
  // -----------------------------------------------------------------
  localparam int MODE_OVF_BIT = 7;
  localparam int MODE_RISE_IE_BIT = 5;
  localparam int MODE_FALL_IE_BIT = 4;
  localparam int MODE_RESP_LSB = 0;
  // -----------------------------------------------------------------
  // input select register fields and codes
  // -----------------------------------------------------------------
  localparam int MUX_NEG_LSB = 4;
  localparam int MUX_POS_LSB = 0;
  localparam logic [3:0] SEL_INTERNAL = 4'h8;
  // hysteresis levels, both polarities
  typedef enum logic [1:0] {
    HYST_OFF = 2'h0,
    HYST_5MV = 2'h1,
    HYST_10MV = 2'h2,
    HYST_20MV = 2'h3
  } cmpctl_hyst_t;
endpackage
`default_nettype wire

// file: verilog/cmpctl_mux_if.sv
// cmpctl_mux_if: select code and decoded routing of one comparator input
`default_nettype none
interface cmpctl_mux_if #(parameter int NUM_CH = 8);
  logic [3:0] sel;
  logic [NUM_CH-1:0] ext_ch;
  logic internal;
  logic none;
  modport dec (input sel, output ext_ch, output internal, output none);
  modport use_side (output sel, input ext_ch, input internal, input none);
endinterface
`default_nettype wire

// file: verilog/cmpctl_mux_dec.sv
// cmpctl_mux_dec: decodes one input select code into analog switch enables
`default_nettype none
module cmpctl_mux_dec #(
  parameter int NUM_CH = 8
) (
  // select code in, switch enables out
  cmpctl_mux_if.dec mux
);
  // -----------------------------------------------------------------
  // decode: low codes pick an external channel, code 8 the internal
  // source, all higher codes leave the input open
  // -----------------------------------------------------------------
  always_comb begin
    mux.ext_ch = '0;
    mux.internal = 1'b0;
    mux.none = 1'b0;
    if (mux.sel < cmpctl_pkg::SEL_INTERNAL) begin
      mux.ext_ch[mux.sel[2:0]] = 1'b1;
    end else if (mux.sel == cmpctl_pkg::SEL_INTERNAL) begin
      mux.internal = 1'b1;
    end else begin
      mux.none = 1'b1;
    end
  end
  // at most one switch is ever closed
  a_one_switch: assert property (@(mux.sel)
    $onehot0({mux.ext_ch, mux.internal})) else $error("two switches closed");
endmodule
`default_nettype wire

// file: verilog/cmpctl_top.sv
// cmpctl_top: control and status logic around an analog comparator
//
// Summary of operation
// - second comparator positive select: channels, regulator, open
// - second comparator negative select: channels, ground, open
// - clocked output and raw asynchronous output
// - raw output stays valid without clock
// - disabled: pin outputs low, analog supply off
// - control bit 7 enables, resets disabled
// - control bit 6 reads current result
// - rising edge sets sticky bit 5
// - falling edge sets sticky bit 4
// - positive hysteresis in control bits 3:2
// - negative hysteresis in control bits 1:0
// - mode bit 7 captures result at overflow
// - mode bit 5 gates rising interrupt
// - mode bit 4 gates falling interrupt
// - mode bits 1:0 response mode, reset 10
// - interrupts on both edges, separate gates
// - first comparator select: negative 7:4, positive 3:0
`default_nettype none
module cmpctl_top #(
  parameter int NUM_CH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // analog comparator core
  input wire logic cmp_raw,
  output logic cmp_enable,
  output logic [1:0] pos_hyst_sel,
  output logic [1:0] neg_hyst_sel,
  output logic [1:0] response_mode_sel,
  // first comparator input switches
  output logic [NUM_CH-1:0] cmp0_pos_ch,
  output logic cmp0_pos_regulator,
  output logic [NUM_CH-1:0] cmp0_neg_ch,
  output logic cmp0_neg_ground,
  // second comparator input selects and switches
  input wire logic [3:0] pos_input_sel,
  input wire logic [3:0] neg_input_sel,
  output logic [NUM_CH-1:0] cmp1_pos_channel,
  output logic cmp1_pos_regulator,
  output logic [NUM_CH-1:0] cmp1_neg_channel,
  output logic cmp1_neg_ground,
  // counter overflow event
  input wire logic cnt_overflow,
  // pin outputs and interrupt request
  output logic raw_async_out,
  output logic sync_latched_out,
  output logic cmp_irq
);
  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic cmp_enable_r;
  logic rise_flag_r;
  logic fall_flag_r;
  logic [1:0] pos_hyst_r;
  logic [1:0] neg_hyst_r;
  logic overflow_sampled_result_r;
  logic rise_irq_en_r;
  logic fall_irq_en_r;
  logic [1:0] response_mode_r;
  logic [7:0] cmp0_input_select_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic sync1_r;
  logic cmp_result_r;
  logic result_prev_r;
  logic sync_out_r;
  logic rise_edge;
  logic fall_edge;
  logic raw_gated;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_mux0;
  logic [7:0] ctrl_view;
  logic [7:0] mode_view;

  assign wr_ctrl = sfr_wr && (sfr_addr == cmpctl_pkg::CTRL_ADDR);
  assign wr_mode = sfr_wr && (sfr_addr == cmpctl_pkg::MODE_ADDR);
  assign wr_mux0 = sfr_wr && (sfr_addr == cmpctl_pkg::MUX0_ADDR);

  // -----------------------------------------------------------------
  // raw output path, no flip-flop in the way
  // -----------------------------------------------------------------
  // the enable is static while the clock is stopped, so the gated raw
  // result keeps following the analog core
  assign raw_gated = cmp_raw & cmp_enable_r;
  assign raw_async_out = raw_gated;

  // -----------------------------------------------------------------
  // enable and hysteresis controls
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmp_enable_r <= cmpctl_pkg::CTRL_RST[cmpctl_pkg::CTRL_EN_BIT];
      pos_hyst_r <= cmpctl_pkg::HYST_OFF;
      neg_hyst_r <= cmpctl_pkg::HYST_OFF;
    end else if (wr_ctrl) begin
      cmp_enable_r <= sfr_wdata[cmpctl_pkg::CTRL_EN_BIT];
      pos_hyst_r <= sfr_wdata[cmpctl_pkg::CTRL_HYP_LSB +: 2];
      neg_hyst_r <= sfr_wdata[cmpctl_pkg::CTRL_HYN_LSB +: 2];
    end
  end

  // analog supply and trims follow the registers directly
  assign cmp_enable = cmp_enable_r;
  assign pos_hyst_sel = pos_hyst_r;
  assign neg_hyst_sel = neg_hyst_r;
  assign response_mode_sel = response_mode_r;

  // -----------------------------------------------------------------
  // synchroniser and edge detection
  // -----------------------------------------------------------------
  // two flops against metastability, a third holds the previous sample
  // so that each transition yields exactly one edge pulse
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      cmp_result_r <= 1'b0;
      result_prev_r <= 1'b0;
    end else begin
      sync1_r <= raw_gated;
      cmp_result_r <= sync1_r;
      result_prev_r <= cmp_result_r;
    end
  end

  assign rise_edge = cmp_result_r & ~result_prev_r;
  assign fall_edge = ~cmp_result_r & result_prev_r;

  // clocked pin output; low from the cycle after the comparator is switched off
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync_out_r <= 1'b0;
    end else begin
      sync_out_r <= cmp_result_r & cmp_enable_r;
    end
  end
  assign sync_latched_out = sync_out_r;

  // -----------------------------------------------------------------
  // sticky edge flags
  // -----------------------------------------------------------------
  // a new edge wins over a software clear in the same cycle, so an
  // event is never lost to a badly timed write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rise_flag_r <= 1'b0;
    end else if (rise_edge) begin
      rise_flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      rise_flag_r <= sfr_wdata[cmpctl_pkg::CTRL_RISE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fall_flag_r <= 1'b0;
    end else if (fall_edge) begin
      fall_flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      fall_flag_r <= sfr_wdata[cmpctl_pkg::CTRL_FALL_BIT];
    end
  end

  // -----------------------------------------------------------------
  // mode register
  // -----------------------------------------------------------------
  // reserved bits are not stored; they read back as their reset value
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rise_irq_en_r <= 1'b0;
      fall_irq_en_r <= 1'b0;
      response_mode_r <= cmpctl_pkg::RESP_MODE_RST;
    end else if (wr_mode) begin
      rise_irq_en_r <= sfr_wdata[cmpctl_pkg::MODE_RISE_IE_BIT];
      fall_irq_en_r <= sfr_wdata[cmpctl_pkg::MODE_FALL_IE_BIT];
      response_mode_r <= sfr_wdata[cmpctl_pkg::MODE_RESP_LSB +: 2];
    end
  end

  // overflow capture wins over a software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      overflow_sampled_result_r <= 1'b0;
    end else if (cnt_overflow) begin
      overflow_sampled_result_r <= cmp_result_r;
    end else if (wr_mode) begin
      overflow_sampled_result_r <= sfr_wdata[cmpctl_pkg::MODE_OVF_BIT];
    end
  end

  // -----------------------------------------------------------------
  // interrupt request
  // -----------------------------------------------------------------
  assign cmp_irq = (rise_flag_r & rise_irq_en_r)
    | (fall_flag_r & fall_irq_en_r);

  // -----------------------------------------------------------------
  // input select decode for both comparators
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmp0_input_select_r <= cmpctl_pkg::MUX0_RST;
    end else if (wr_mux0) begin
      cmp0_input_select_r <= sfr_wdata;
    end
  end

  cmpctl_mux_if #(.NUM_CH(NUM_CH)) m0p ();
  cmpctl_mux_if #(.NUM_CH(NUM_CH)) m0n ();
  cmpctl_mux_if #(.NUM_CH(NUM_CH)) m1p ();
  cmpctl_mux_if #(.NUM_CH(NUM_CH)) m1n ();

  assign m0p.sel = cmp0_input_select_r[cmpctl_pkg::MUX_POS_LSB +: 4];
  assign m0n.sel = cmp0_input_select_r[cmpctl_pkg::MUX_NEG_LSB +: 4];
  assign m1p.sel = pos_input_sel;
  assign m1n.sel = neg_input_sel;

  cmpctl_mux_dec #(.NUM_CH(NUM_CH)) u_dec0p (.mux(m0p));
  cmpctl_mux_dec #(.NUM_CH(NUM_CH)) u_dec0n (.mux(m0n));
  cmpctl_mux_dec #(.NUM_CH(NUM_CH)) u_dec1p (.mux(m1p));
  cmpctl_mux_dec #(.NUM_CH(NUM_CH)) u_dec1n (.mux(m1n));

  // internal code means regulator on the plus side, ground on minus
  assign cmp0_pos_ch = m0p.ext_ch;
  assign cmp0_pos_regulator = m0p.internal;
  assign cmp0_neg_ch = m0n.ext_ch;
  assign cmp0_neg_ground = m0n.internal;
  assign cmp1_pos_channel = m1p.ext_ch;
  assign cmp1_pos_regulator = m1p.internal;
  assign cmp1_neg_channel = m1n.ext_ch;
  assign cmp1_neg_ground = m1n.internal;

  // -----------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------
  assign ctrl_view = {cmp_enable_r, cmp_result_r, rise_flag_r,
    fall_flag_r, pos_hyst_r, neg_hyst_r};
  assign mode_view = {overflow_sampled_result_r, 1'b0, rise_irq_en_r,
    fall_irq_en_r, 2'b00, response_mode_r};

  // unmapped addresses read as zero; data is held between reads
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd) begin
      case (sfr_addr)
        cmpctl_pkg::CTRL_ADDR: rdata_nxt = ctrl_view;
        cmpctl_pkg::MODE_ADDR: rdata_nxt = mode_view;
        cmpctl_pkg::MUX0_ADDR: rdata_nxt = cmp0_input_select_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign sfr_rdata = rdata_r;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_raw_gated_off: assert property (
    !cmp_enable_r |-> !raw_async_out) else $error("raw out high while off");
  a_sync_out_off: assert property (
    !$past(cmp_enable_r) |-> !sync_latched_out)
    else $error("sync out high while off");
  a_rise_sets: assert property (
    $rose(cmp_result_r) |=> rise_flag_r) else $error("rise flag not set");
  a_fall_sets: assert property (
    $fell(cmp_result_r) |=> fall_flag_r) else $error("fall flag not set");
  a_rise_sticky: assert property (
    rise_flag_r && !wr_ctrl |=> rise_flag_r)
    else $error("rise flag lost");
  a_fall_sticky: assert property (
    fall_flag_r && !wr_ctrl |=> fall_flag_r)
    else $error("fall flag lost");
  a_edge_once: assert property (
    rise_edge |=> !rise_edge) else $error("double rise edge");
  a_result_path: assert property (
    (cmp_enable_r && $stable(cmp_enable_r) && $stable(cmp_raw)) [*3]
    |-> cmp_result_r == cmp_raw) else $error("result not synchronised");
  a_ovf_capture: assert property (
    cnt_overflow |=> overflow_sampled_result_r == $past(cmp_result_r))
    else $error("overflow capture wrong");
  a_ovf_hold: assert property (
    !cnt_overflow && !wr_mode |=> $stable(overflow_sampled_result_r))
    else $error("overflow sample changed");
  a_irq_gate: assert property (
    cmp_irq == ((rise_flag_r && rise_irq_en_r)
      || (fall_flag_r && fall_irq_en_r))) else $error("irq gating wrong");
  a_ctrl_read: assert property (
    sfr_rd && sfr_addr == cmpctl_pkg::CTRL_ADDR
    |=> sfr_rdata[cmpctl_pkg::CTRL_RES_BIT] == $past(cmp_result_r))
    else $error("result bit read wrong");
  a_mode_reset: assert property (
    $rose(reset_n) |-> response_mode_r == cmpctl_pkg::RESP_MODE_RST)
    else $error("mode reset value wrong");
  // a software write of zero clears a flag only when no edge competes
  a_rise_clear: assert property (
    wr_ctrl && !sfr_wdata[cmpctl_pkg::CTRL_RISE_BIT] && !rise_edge
    |=> !rise_flag_r) else $error("rise flag not cleared");
  a_fall_clear: assert property (
    wr_ctrl && !sfr_wdata[cmpctl_pkg::CTRL_FALL_BIT] && !fall_edge
    |=> !fall_flag_r) else $error("fall flag not cleared");
  // the analog supply follows the enable bit from the next cycle on
  a_enable_on: assert property (
    wr_ctrl && sfr_wdata[cmpctl_pkg::CTRL_EN_BIT] |=> cmp_enable)
    else $error("comparator not enabled");
  a_enable_off: assert property (
    wr_ctrl && !sfr_wdata[cmpctl_pkg::CTRL_EN_BIT] |=> !cmp_enable)
    else $error("comparator not disabled");
  // codes above the internal source must leave both inputs open
  a_sel1_pos_open: assert property (
    pos_input_sel > cmpctl_pkg::SEL_INTERNAL
    |-> !cmp1_pos_regulator && cmp1_pos_channel == '0)
    else $error("open positive input connected");
  a_sel1_neg_open: assert property (
    neg_input_sel > cmpctl_pkg::SEL_INTERNAL
    |-> !cmp1_neg_ground && cmp1_neg_channel == '0)
    else $error("open negative input connected");

  c_rise_irq: cover property (rise_flag_r && rise_irq_en_r);
  c_fall_irq: cover property (fall_flag_r && fall_irq_en_r);
  c_clear_race: cover property (wr_ctrl && rise_edge);
  c_overflow: cover property (cnt_overflow && cmp_result_r);
endmodule
`default_nettype wire

// file: tb/cmpctl_analog_model.sv
// cmpctl_analog_model: analog input pair feeding the comparator core
`default_nettype none
module cmpctl_analog_model (
  // clock, only used for the unpowered noise pattern
  input wire logic core_clk,
  // supply from the block
  input wire logic cmp_enable,
  // pin voltages in millivolts
  input var int plus_mv,
  input var int minus_mv,
  // comparator core result
  output logic cmp_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic noise_r = 1'b0;
  // an unpowered core has no defined level, so toggle every cycle
  always @(posedge core_clk) begin
    noise_r <= ~noise_r;
  end
  // powered core: high only while plus exceeds minus, no clock needed
  assign cmp_raw = cmp_enable ? (plus_mv > minus_mv) : noise_r;
endmodule
`default_nettype wire

// file: tb/comparator_control_logic_tb.sv
// comparator_control_logic_tb: self-checking bench for cmpctl_top
`default_nettype none
module comparator_control_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, clk_run = 1'b1, reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, cnt_overflow = 1'b0;
  logic [3:0] pos_input_sel = 4'h0, neg_input_sel = 4'h0;
  logic cmp_raw, cmp_enable, raw_async_out, sync_latched_out, cmp_irq;
  logic [1:0] pos_hyst_sel, neg_hyst_sel, response_mode_sel;
  logic [7:0] cmp0_pos_ch, cmp0_neg_ch, cmp1_pos_channel, cmp1_neg_channel;
  logic cmp0_pos_regulator, cmp0_neg_ground;
  logic cmp1_pos_regulator, cmp1_neg_ground;
  int plus_mv = 0, minus_mv = 100, miscompares = 0, checked = 0;
  int en_m = 0, rf_m = 0, ff_m = 0, hp_m = 0, hn_m = 0, ovf_m = 0, lvl = 0;
  logic [7:0] mode_m = 8'h02, v;
  // ---------------------------------------------------------------
  // clock, stoppable for the clockless raw-output check
  // ---------------------------------------------------------------
  initial begin
    forever begin
      #25;
      if (clk_run) core_clk = ~core_clk;
    end
  end
  cmpctl_top #(.NUM_CH(8)) cmpctl_top_i (
    .core_clk(core_clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
    .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel),
    .response_mode_sel(response_mode_sel), .cmp0_pos_ch(cmp0_pos_ch),
    .cmp0_pos_regulator(cmp0_pos_regulator), .cmp0_neg_ch(cmp0_neg_ch),
    .cmp0_neg_ground(cmp0_neg_ground), .pos_input_sel(pos_input_sel),
    .neg_input_sel(neg_input_sel), .cmp1_pos_channel(cmp1_pos_channel),
    .cmp1_pos_regulator(cmp1_pos_regulator),
    .cmp1_neg_channel(cmp1_neg_channel), .cmp1_neg_ground(cmp1_neg_ground),
    .cnt_overflow(cnt_overflow), .raw_async_out(raw_async_out),
    .sync_latched_out(sync_latched_out), .cmp_irq(cmp_irq));
  cmpctl_analog_model cmpctl_analog_model_i (
    .core_clk(core_clk), .cmp_enable(cmp_enable), .plus_mv(plus_mv),
    .minus_mv(minus_mv), .cmp_raw(cmp_raw));
  // ---------------------------------------------------------------
  // reference model, comparison and bus tasks
  // ---------------------------------------------------------------
  // switch enables for one select code: {internal, channels}
  function automatic logic [15:0] dec(input int code);
    dec = (code < 9) ? 16'(1 << code) : 16'h0000;
  endfunction
  function automatic logic [7:0] ctrl_exp(input int res);
    ctrl_exp = {1'(en_m), 1'(res), 1'(rf_m), 1'(ff_m), 2'(hp_m), 2'(hn_m)};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobe, launched and dropped on falling edges
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask
  // read data is registered, so it is settled one falling edge later
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    check(16'(sfr_rdata), 16'(exp));
  endtask
  // move the pins across the threshold and watch the clocked output
  task automatic edge_step(input int nl);
    @(negedge core_clk);
    plus_mv = nl ? minus_mv + 1 + 32'($urandom_range(50)) : minus_mv - 1;
    if (nl > lvl) rf_m = 1;
    if (nl < lvl) ff_m = 1;
    repeat (2) @(negedge core_clk);
    check(16'(sync_latched_out), 16'(lvl));
    @(negedge core_clk);
    check(16'(sync_latched_out), 16'(nl));
    lvl = nl;
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // bounded run time
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    v = 8'($urandom(32'h02B4));
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    reg_rd(cmpctl_pkg::CTRL_ADDR, 8'h00);
    reg_rd(cmpctl_pkg::MODE_ADDR, 8'h02);
    reg_rd(cmpctl_pkg::MUX0_ADDR, 8'hFF);
    reg_wr(8'h9C, 8'hFF);
    reg_rd(8'h9C, 8'h00);
    check(16'(cmp_enable), 16'h0000);
    check(16'(response_mode_sel), 16'h0002);
    // every select code on the second comparator, random codes on the first except 8'h88 at code 8
    for (int c = 0; c < 16; c++) begin
      @(negedge core_clk);
      pos_input_sel = 4'(c);
      neg_input_sel = 4'(15 - c);
      #1;
      check({cmp1_pos_regulator, cmp1_pos_channel}, dec(c));
      check({cmp1_neg_ground, cmp1_neg_channel}, dec(15 - c));
      v = (c == 8) ? 8'h88 : 8'($urandom);
      reg_wr(cmpctl_pkg::MUX0_ADDR, v);
      check({cmp0_pos_regulator, cmp0_pos_ch}, dec(int'(v[3:0])));
      check({cmp0_neg_ground, cmp0_neg_ch}, dec(int'(v[7:4])));
      reg_rd(cmpctl_pkg::MUX0_ADDR, v);
    end
    // hysteresis and response codes, disabled core toggling meanwhile
    for (int c = 0; c < 4; c++) begin
      hp_m = c;
      hn_m = 3 - c;
      reg_wr(cmpctl_pkg::CTRL_ADDR, ctrl_exp(0) | 8'h40);
      check(16'(pos_hyst_sel), 16'(c));
      check(16'(neg_hyst_sel), 16'(3 - c));
      mode_m = 8'(c) | (8'($urandom) & 8'h30);
      reg_wr(cmpctl_pkg::MODE_ADDR, mode_m);
      check(16'(response_mode_sel), 16'(c));
      reg_rd(cmpctl_pkg::CTRL_ADDR, ctrl_exp(0));
      reg_rd(cmpctl_pkg::MODE_ADDR, mode_m);
      check(16'({raw_async_out, sync_latched_out, cmp_irq}), 16'h0);
    end
    // enable, then clear spurious flags before unmasking interrupts
    en_m = 1;
    reg_wr(cmpctl_pkg::CTRL_ADDR, ctrl_exp(0));
    check(16'(cmp_enable), 16'h0001);
    repeat (3) @(negedge core_clk);
    rf_m = 0;
    ff_m = 0;
    reg_wr(cmpctl_pkg::CTRL_ADDR, ctrl_exp(0));
    mode_m = 8'h32;
    reg_wr(cmpctl_pkg::MODE_ADDR, mode_m);
    check(16'(cmp_irq), 16'h0000);
    edge_step(1);
    check(16'(cmp_irq), 16'h0001);
    reg_rd(cmpctl_pkg::CTRL_ADDR, ctrl_exp(1));
    mode_m = 8'h12;
    reg_wr(cmpctl_pkg::MODE_ADDR, mode_m);
    check(16'(cmp_irq), 16'h0000);
    rf_m = 0;
    reg_wr(cmpctl_pkg::CTRL_ADDR, ctrl_exp(1));
    edge_step(0);
    check(16'(cmp_irq), 16'h0001);
    repeat (5) @(negedge core_clk);
    reg_rd(cmpctl_pkg::CTRL_ADDR, ctrl_exp(0));
    mode_m = 8'h22;
    reg_wr(cmpctl_pkg::MODE_ADDR, mode_m);
    check(16'(cmp_irq), 16'h0000);
    // overflow capture holds until the next overflow
    for (int k = 1; k >= 0; k--) begin
      edge_step(k);
      @(negedge core_clk);
      cnt_overflow = 1'b1;
      @(negedge core_clk);
      cnt_overflow = 1'b0;
      ovf_m = k;
      edge_step(1 - k);
      reg_rd(cmpctl_pkg::MODE_ADDR, {1'(ovf_m), mode_m[6:0]});
      reg_rd(cmpctl_pkg::CTRL_ADDR, ctrl_exp(lvl));
    end
    // raw output follows the pins with the clock stopped
    @(negedge core_clk);
    clk_run = 1'b0;
    for (int k = 0; k < 2; k++) begin
      plus_mv = (k == lvl) ? minus_mv + 5 : minus_mv - 5;
      #100;
      check(16'(raw_async_out), 16'(k == lvl));
    end
    clk_run = 1'b1;
    #1;
    check(16'(raw_async_out), 16'(lvl));
    // disabling while high drops the enable and both pin outputs and flags a fall; the rise flag stays set, so cmp_irq stays high
    en_m = 0;
    ff_m = 0;
    reg_wr(cmpctl_pkg::CTRL_ADDR, ctrl_exp(0));
    ff_m = lvl;
    repeat (4) @(negedge core_clk);
    check(16'({cmp_enable, raw_async_out, sync_latched_out}), 16'h0);
    reg_rd(cmpctl_pkg::CTRL_ADDR, ctrl_exp(0));
    complete_run();
  end
endmodule
`default_nettype wire
